/* File: rtl/ptd_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the pulse-per-second timing block
// Assumes: 200 MHz system clock, 10 MHz reference derived by counting
// Notes: All offsets are byte addresses on a 32-bit classic Wishbone bus
//////////////////////////////////////////////////////////////////////////////
package ptd_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_PERIOD_NS = 100;
  localparam int REF_CYCLES = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_PERIOD_NS = 400;
  localparam int PHASES = BUS_PERIOD_NS / REF_PERIOD_NS;
  localparam int REF_CNT_W = 5;

  // Output pulse timing, counted in bus clock periods
  localparam int PULSE_WIDTH_NS = 10000;
  localparam int PULSE_WIDTH_BUS = PULSE_WIDTH_NS / BUS_PERIOD_NS;
  localparam int PPS_PERIOD_NS = 1000000000;
  localparam int PPS_PERIOD_BUS_DEF = PPS_PERIOD_NS / BUS_PERIOD_NS;
  localparam int SEC_W = 22;

  // Fine interval stretch and fine output delay
  localparam int STRETCH_FACTOR = 2000;
  localparam int GATE_W = 8;
  localparam int STRETCH_W = 20;
  localparam int FINE_STEP_PS = 500;
  localparam int FINE_CODE_MAX = 255;
  localparam int FINE_TAPS = (FINE_CODE_MAX * FINE_STEP_PS) / CLK_PERIOD_PS + 1;
  localparam int FINE_IDX_W = 5;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OFFSET = 8'h04;
  localparam logic [7:0] REG_FINE_CODE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_COARSE_TAG = 8'h10;
  localparam logic [7:0] REG_FINE_TAG = 8'h14;
  localparam logic [7:0] REG_GATE_WIDTH = 8'h18;
  localparam logic [7:0] REG_BUS_COUNT = 8'h1C;

  // Control register fields
  localparam int CTRL_CAPTURE_ENABLE_CLEAR = 0;
  localparam int CTRL_PULSE_OUTPUT_PORT_BIT = 1;
  localparam int CTRL_TIMER_EN = 2;
  localparam int CTRL_COARSE_DELAY_SELECT_LOW = 3;
  localparam int CTRL_COARSE_DELAY_SELECT_HIGH = 4;
  localparam int CTRL_W = 5;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_COARSE_VALID = 8;
  localparam int STAT_FINE_VALID = 9;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [SEC_W-1:0] OFFSET_RST = 22'h000000;
  localparam logic [7:0] FINE_CODE_RST = 8'h00;

  // Time-tag sequencer states
  typedef enum logic [5:0] {
    TT_IDLE = 6'h01,
    TT_ARMED = 6'h02,
    TT_WAIT90 = 6'h04,
    TT_WAIT180 = 6'h08,
    TT_STRETCH = 6'h10,
    TT_DONE = 6'h20
  } ptd_tt_state_e;

endpackage

/* File: rtl/ptd_pps_timing.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Time-tags a pulse-per-second input and places a delayed pulse output
// Assumes: pps_i synchronous to clk_i; Wishbone classic slave, 32-bit words
// Notes: Reference and bus clock phases are derived by counting clk_i
//
// Overview of operation
// - Time-tag input rising edge to nanosecond resolution
// - Coarse strobe is input resynchronized to bus clock
// - Both strobes capture the bus clock counter
// - Bus clock locked to reference; four phases produced
// - Zero phase synchronizes capture enable/clear control
// - Arm on ninety phase; no gate before arming
// - Gate starts at first input edge after arming
// - Gate ends at 180 after first 90
// - Gate lasts 100 to 500 ns
// - Fine signal low about 2000 times gate
// - Output 10 us pulse at 1 Hz
// - Timer places pulse in 400 ns steps
// - Port bit synced at zero phase, then stage
// - Two select bits pick one of four phases
// - Eight-bit code adds 0.5 ns per code, rounded down to 5 ns steps
// - Fine delay equal on both edges
// - Coarse, phase and fine combine for placement
//////////////////////////////////////////////////////////////////////////////
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ptd_pps_timing
  import ptd_pkg::*;
#(
  parameter int PPS_PERIOD_BUS = PPS_PERIOD_BUS_DEF,
  parameter int TAG_W = 16
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pulse-per-second pins
  input wire logic pps_i,
  output logic pps_o,
  // Timing observation
  output logic bus_clk_o,
  output logic coarse_strobe_o,
  output logic gate_o,
  output logic fine_interval_signal_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file state

  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [SEC_W-1:0] offset_r, offset_nxt;
  logic [7:0] fine_code_r, fine_code_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Time base: reference ticks, bus clock phases, free-running counter

  logic [REF_CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic bus_clk_r, bus_clk_nxt;
  logic [TAG_W-1:0] bus_cnt_r, bus_cnt_nxt;
  logic ref_tick, e0_rise, e90_rise, e180_rise;

  // Phase decode, one reference period per phase
  assign ref_tick = (ref_cnt_r == REF_CNT_W'(REF_CYCLES - 1));
  assign e0_rise = ref_tick && (phase_r == 2'(PHASES - 1));
  assign e90_rise = ref_tick && (phase_r == 2'h0);
  assign e180_rise = ref_tick && (phase_r == 2'h1);

  // Next time base values
  always_comb begin
    ref_cnt_nxt = ref_tick ? '0 : ref_cnt_r + REF_CNT_W'(1);
    phase_nxt = ref_tick ? phase_r + 2'h1 : phase_r;
    bus_clk_nxt = (phase_nxt < 2'h2);
    bus_cnt_nxt = e0_rise ? bus_cnt_r + TAG_W'(1) : bus_cnt_r;
  end

  // Time base registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_cnt_r <= REF_CNT_W'(REF_CYCLES - 1); // Last tick of phase 3
      phase_r <= 2'(PHASES - 1); // First phase after release is full length
      bus_clk_r <= 1'b0;
      bus_cnt_r <= '0;
    end else if (ce_i) begin
      ref_cnt_r <= ref_cnt_nxt;
      phase_r <= phase_nxt;
      bus_clk_r <= bus_clk_nxt;
      bus_cnt_r <= bus_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input time-tag: coarse strobe, gate and stretched fine interval

  ptd_tt_state_e state_r, state_nxt;
  logic en_sync_r, en_sync_nxt;
  logic pps_bus_r, pps_bus_nxt;
  logic pps_prev_r, pps_prev_nxt;
  logic coarse_strobe_r, coarse_strobe_nxt;
  logic coarse_valid_r, coarse_valid_nxt;
  logic fine_valid_r, fine_valid_nxt;
  logic [TAG_W-1:0] coarse_tag_r, coarse_tag_nxt;
  logic [TAG_W-1:0] fine_tag_r, fine_tag_nxt;
  logic [GATE_W-1:0] gate_cnt_r, gate_cnt_nxt;
  logic [GATE_W-1:0] gate_width_r, gate_width_nxt;
  logic [STRETCH_W-1:0] stretch_r, stretch_nxt;
  logic gate_r, gate_nxt;
  logic fine_int_r, fine_int_nxt;
  logic pps_rise;

  assign pps_rise = pps_i && !pps_prev_r;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    en_sync_nxt = e0_rise ? ctrl_r[CTRL_CAPTURE_ENABLE_CLEAR] : en_sync_r;
    pps_bus_nxt = e0_rise ? pps_i : pps_bus_r;
    coarse_strobe_nxt = e0_rise && pps_i && !pps_bus_r;
    pps_prev_nxt = pps_i;
    coarse_valid_nxt = coarse_valid_r;
    fine_valid_nxt = fine_valid_r;
    coarse_tag_nxt = coarse_tag_r;
    fine_tag_nxt = fine_tag_r;
    gate_cnt_nxt = gate_cnt_r;
    gate_width_nxt = gate_width_r;
    stretch_nxt = stretch_r;
    if (!en_sync_r) begin
      state_nxt = TT_IDLE;
      coarse_valid_nxt = 1'b0;
      fine_valid_nxt = 1'b0;
    end else begin
      // Coarse tag, once per armed measurement
      if (coarse_strobe_r && (state_r != TT_IDLE) && !coarse_valid_r) begin
        coarse_tag_nxt = bus_cnt_r;
        coarse_valid_nxt = 1'b1;
      end
      unique case (state_r)
        TT_IDLE: begin
          if (e90_rise) begin
            state_nxt = TT_ARMED;
          end
        end
        TT_ARMED: begin
          if (pps_rise) begin
            state_nxt = TT_WAIT90;
            gate_cnt_nxt = GATE_W'(1);
          end
        end
        TT_WAIT90: begin
          gate_cnt_nxt = gate_cnt_r + GATE_W'(1);
          if (e90_rise) begin
            state_nxt = TT_WAIT180;
          end
        end
        TT_WAIT180: begin
          gate_cnt_nxt = gate_cnt_r + GATE_W'(1);
          if (e180_rise) begin
            state_nxt = TT_STRETCH;
            gate_width_nxt = gate_cnt_r;
            stretch_nxt = STRETCH_W'(gate_cnt_r) * STRETCH_W'(STRETCH_FACTOR);
          end
        end
        TT_STRETCH: begin
          stretch_nxt = stretch_r - STRETCH_W'(1);
          if (stretch_r == STRETCH_W'(1)) begin
            state_nxt = TT_DONE;
            fine_tag_nxt = bus_cnt_r;
            fine_valid_nxt = 1'b1;
          end
        end
        TT_DONE: begin
          state_nxt = TT_DONE;
        end
        default: begin
          state_nxt = TT_IDLE;
        end
      endcase
    end
    gate_nxt = (state_nxt == TT_WAIT90) || (state_nxt == TT_WAIT180);
    fine_int_nxt = (state_nxt != TT_STRETCH);
  end

  // Sequencer registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= TT_IDLE;
      en_sync_r <= 1'b0;
      pps_bus_r <= 1'b0;
      pps_prev_r <= 1'b0;
      coarse_strobe_r <= 1'b0;
      coarse_valid_r <= 1'b0;
      fine_valid_r <= 1'b0;
      coarse_tag_r <= '0;
      fine_tag_r <= '0;
      gate_cnt_r <= '0;
      gate_width_r <= '0;
      stretch_r <= '0;
      gate_r <= 1'b0;
      fine_int_r <= 1'b1;
    end else if (ce_i) begin
      state_r <= state_nxt;
      en_sync_r <= en_sync_nxt;
      pps_bus_r <= pps_bus_nxt;
      pps_prev_r <= pps_prev_nxt;
      coarse_strobe_r <= coarse_strobe_nxt;
      coarse_valid_r <= coarse_valid_nxt;
      fine_valid_r <= fine_valid_nxt;
      coarse_tag_r <= coarse_tag_nxt;
      fine_tag_r <= fine_tag_nxt;
      gate_cnt_r <= gate_cnt_nxt;
      gate_width_r <= gate_width_nxt;
      stretch_r <= stretch_nxt;
      gate_r <= gate_nxt;
      fine_int_r <= fine_int_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pulse: timer, zero-phase sync, phase select, fine delay

  logic [SEC_W-1:0] sec_cnt_r, sec_cnt_nxt;
  logic pulse_e0_r, pulse_e0_nxt;
  logic pps_out_r, pps_out_nxt;
  logic [PHASES-1:0] phase_taps;
  logic [FINE_TAPS-1:0] fine_taps;
  logic [SEC_W:0] pulse_end;
  logic timer_bit, port_bit, phase_sel_bit;
  logic [1:0] phase_sel;
  logic [FINE_IDX_W-1:0] fine_idx;

  // Timer window, 400 ns resolution
  assign pulse_end = {1'b0, offset_r} + (SEC_W + 1)'(PULSE_WIDTH_BUS);
  assign timer_bit = (sec_cnt_r >= offset_r) && ({1'b0, sec_cnt_r} < pulse_end);
  assign port_bit = ctrl_r[CTRL_TIMER_EN] ? timer_bit : ctrl_r[CTRL_PULSE_OUTPUT_PORT_BIT];
  assign phase_sel = {ctrl_r[CTRL_COARSE_DELAY_SELECT_HIGH],
                      ctrl_r[CTRL_COARSE_DELAY_SELECT_LOW]};
  assign phase_sel_bit = phase_taps[phase_sel];
  assign fine_idx = FINE_IDX_W'((STRETCH_W'(fine_code_r) * STRETCH_W'(FINE_STEP_PS))
                                / STRETCH_W'(CLK_PERIOD_PS));

  // Next output path values
  always_comb begin
    sec_cnt_nxt = sec_cnt_r;
    if (e0_rise) begin
      sec_cnt_nxt = (sec_cnt_r == SEC_W'(PPS_PERIOD_BUS - 1)) ? '0 : sec_cnt_r + SEC_W'(1);
    end
    pulse_e0_nxt = e0_rise ? port_bit : pulse_e0_r;
    pps_out_nxt = fine_taps[fine_idx];
  end

  // Output path registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sec_cnt_r <= '0;
      pulse_e0_r <= 1'b0;
      pps_out_r <= 1'b0;
    end else if (ce_i) begin
      sec_cnt_r <= sec_cnt_nxt;
      pulse_e0_r <= pulse_e0_nxt;
      pps_out_r <= pps_out_nxt;
    end
  end

  // Four 100 ns phase copies of the synced pulse
  ptd_shift #(.W(PHASES)) u_phase_stage (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .shift_i(ref_tick),
    .d_i(pulse_e0_r),
    .q_o(phase_taps)
  );

  // Fine delay line, same delay for both edges
  ptd_shift #(.W(FINE_TAPS)) u_fine_line (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .shift_i(1'b1),
    .d_i(phase_sel_bit),
    .q_o(fine_taps)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic req;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Register writes, read mux and acknowledge
  always_comb begin
    ctrl_nxt = ctrl_r;
    offset_nxt = offset_r;
    fine_code_nxt = fine_code_r;
    rdata_nxt = rdata_r;
    ack_nxt = req;
    if (req && wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl_nxt = CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
        REG_OFFSET: offset_nxt = SEC_W'(merge(32'(offset_r), wb_dat_i, wb_sel_i));
        REG_FINE_CODE: fine_code_nxt = 8'(merge(32'(fine_code_r), wb_dat_i, wb_sel_i));
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: rdata_nxt = 32'(ctrl_r);
        REG_OFFSET: rdata_nxt = 32'(offset_r);
        REG_FINE_CODE: rdata_nxt = 32'(fine_code_r);
        REG_STATUS: rdata_nxt = 32'(state_r) | (32'(coarse_valid_r) << STAT_COARSE_VALID)
                                | (32'(fine_valid_r) << STAT_FINE_VALID);
        REG_COARSE_TAG: rdata_nxt = 32'(coarse_tag_r);
        REG_FINE_TAG: rdata_nxt = 32'(fine_tag_r);
        REG_GATE_WIDTH: rdata_nxt = 32'(gate_width_r);
        REG_BUS_COUNT: rdata_nxt = 32'(bus_cnt_r);
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
      offset_r <= OFFSET_RST;
      fine_code_r <= FINE_CODE_RST;
      rdata_r <= 32'h00000000;
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ctrl_r <= ctrl_nxt;
      offset_r <= offset_nxt;
      fine_code_r <= fine_code_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_o = rdata_r;
  assign wb_ack_o = ack_r;
  assign pps_o = pps_out_r;
  assign bus_clk_o = bus_clk_r;
  assign coarse_strobe_o = coarse_strobe_r;
  assign gate_o = gate_r;
  assign fine_interval_signal_o = fine_int_r;

endmodule

/* File: rtl/ptd_shift.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Enabled shift stage giving W successively delayed copies of d_i
// Assumes: shift_i marks the cycles on which the stage advances
// Notes: Tap 0 is the first delayed copy
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ptd_shift #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Data
  input wire logic shift_i,
  input wire logic d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Next shift contents
  always_comb begin
    q_nxt = q_r;
    if (shift_i) begin
      q_nxt = {q_r[W-2:0], d_i};
    end
  end

  // Shift registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_r <= '0;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;

endmodule

/* File: tb/ptd_pps_src.sv */
// Purpose: Model of an external pulse-per-second reference
// Assumes: output synchronous to clk_i
// Notes: fire_i launches one pulse lead_i cycles after a bus clock rise
`timescale 1ns/1ps
module ptd_pps_src (
  // Clocks
  input wire logic clk_i,
  input wire logic bus_clk_i,
  // Control
  input wire logic fire_i,
  input wire logic [7:0] lead_i,
  // Pulse line
  output logic pps_o
);
  // One pulse per request, placed against the bus clock
  initial begin
    pps_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (fire_i) begin
        @(posedge bus_clk_i);
        repeat (lead_i) @(posedge clk_i);
        pps_o <= 1'b1;
        repeat (200) @(posedge clk_i);
        pps_o <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/ptd_pps_timing_chk.sv */
// Purpose: Port assertions for the pulse-per-second timing block
// Assumes: one clock domain; ce_i held high
// Notes: Bound to every instance of the timing block
`timescale 1ns/1ps
module ptd_pps_timing_chk
  import ptd_pkg::*;
#(
  parameter int PPS_PERIOD_BUS = PPS_PERIOD_BUS_DEF,
  parameter int TAG_W = 16
) (
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Timing pins
  input wire logic pps_i,
  input wire logic pps_o,
  input wire logic bus_clk_o,
  input wire logic coarse_strobe_o,
  input wire logic gate_o,
  input wire logic fine_interval_signal_o
);
  localparam int PULSE_CLK = PULSE_WIDTH_BUS * BUS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int BUS_CLK = BUS_PERIOD_NS / CLK_PERIOD_NS;
  ////////////////////////////////////////
  logic bus_q_r, bus_q_nxt, seen_r, seen_nxt, gate_q_r, gate_q_nxt;
  logic [6:0] bcnt_r, bcnt_nxt, gcnt_r, gcnt_nxt, gcap_r, gcap_nxt;
  logic [17:0] fcnt_r, fcnt_nxt;
  logic [11:0] pcnt_r, pcnt_nxt;
  // Next values of the width and period counters
  always_comb begin
    bus_q_nxt = bus_clk_o;
    gate_q_nxt = gate_o;
    seen_nxt = seen_r | (bus_clk_o & ~bus_q_r);
    bcnt_nxt = (bus_clk_o && !bus_q_r) ? 7'h00 : bcnt_r + 7'h01;
    gcnt_nxt = gate_o ? gcnt_r + 7'h01 : 7'h00;
    gcap_nxt = (gate_q_r && !gate_o) ? gcnt_r : gcap_r;
    fcnt_nxt = fine_interval_signal_o ? 18'h00000 : fcnt_r + 18'h00001;
    pcnt_nxt = pps_o ? pcnt_r + 12'h001 : 12'h000;
  end
  // Counter registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_q_r <= 1'b0;
      seen_r <= 1'b0;
      gate_q_r <= 1'b0;
      bcnt_r <= 7'h00;
      gcnt_r <= 7'h00;
      gcap_r <= 7'h00;
      fcnt_r <= 18'h00000;
      pcnt_r <= 12'h000;
    end else begin
      bus_q_r <= bus_q_nxt;
      seen_r <= seen_nxt;
      gate_q_r <= gate_q_nxt;
      bcnt_r <= bcnt_nxt;
      gcnt_r <= gcnt_nxt;
      gcap_r <= gcap_nxt;
      fcnt_r <= fcnt_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_req; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_gate_end; $fell(gate_o); endsequence
  property p_ack_req; s_req |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acked");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_bus_period; $rose(bus_clk_o) && seen_r |-> bcnt_r == BUS_CLK - 1; endproperty
  a_bus_period: assert property (p_bus_period) else $error("bus clock period");
  property p_bus_half; $fell(bus_clk_o) |-> bcnt_r == BUS_CLK / 2 - 1; endproperty
  a_bus_half: assert property (p_bus_half) else $error("bus clock high time");
  property p_strobe; coarse_strobe_o |-> ($rose(bus_clk_o) || bcnt_r < 3) ##1 !coarse_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("coarse strobe off edge");
  property p_gate_start; $rose(gate_o) |-> $past(pps_i) && !$past(pps_i, 2); endproperty
  a_gate_start: assert property (p_gate_start) else $error("gate without edge");
  property p_gate_end; s_gate_end |-> $fell(bus_clk_o); endproperty
  a_gate_end: assert property (p_gate_end) else $error("gate end off phase");
  property p_gate_width; s_gate_end |-> gcnt_r >= 20 && gcnt_r <= 100; endproperty
  a_gate_width: assert property (p_gate_width) else $error("gate width range");
  property p_fine_start; s_gate_end |-> $fell(fine_interval_signal_o); endproperty
  a_fine_start: assert property (p_fine_start) else $error("fine start");
  property p_fine_len;
    $rose(fine_interval_signal_o) |-> fcnt_r == gcap_r * STRETCH_FACTOR;
  endproperty
  a_fine_len: assert property (p_fine_len) else $error("fine low length");
  property p_pps_width; $fell(pps_o) |-> pcnt_r == PULSE_CLK; endproperty
  a_pps_width: assert property (p_pps_width) else $error("output width");
endmodule
bind ptd_pps_timing ptd_pps_timing_chk #(
  .PPS_PERIOD_BUS(PPS_PERIOD_BUS),
  .TAG_W(TAG_W)
) ptd_pps_timing_chk_i (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pps_i(pps_i), .pps_o(pps_o),
  .bus_clk_o(bus_clk_o), .coarse_strobe_o(coarse_strobe_o), .gate_o(gate_o),
  .fine_interval_signal_o(fine_interval_signal_o)
);

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the pulse-per-second timing block
// Assumes: short second of 40 bus clocks
// Notes: One time-tag run, then output placement steps
`timescale 1ns/1ps
module tb
  import ptd_pkg::*;
();
  localparam int PPS_P = 40;
  localparam int PER = PPS_P * BUS_PERIOD_NS / CLK_PERIOD_NS;
  logic clk_i, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, bus_q;
  logic ack, pps, pps_out, bus_clk, strobe, gate, fine;
  int n_fail, checks, cyc_n, gl, fl, gate_len, fine_len, ngate, nstrobe;
  ////////////////////////////////////////
  ptd_pps_timing #(.PPS_PERIOD_BUS(PPS_P), .TAG_W(16)) ptd_pps_timing_i (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(bus_q),
    .wb_ack_o(ack), .pps_i(pps), .pps_o(pps_out), .bus_clk_o(bus_clk),
    .coarse_strobe_o(strobe), .gate_o(gate), .fine_interval_signal_o(fine));
  ptd_pps_src ptd_pps_src_i (.clk_i(clk_i), .bus_clk_i(bus_clk), .fire_i(fire),
    .lead_i(8'h0E), .pps_o(pps));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Cycle count, watchdog and pin measurements
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 99000) begin
      n_fail++;
      $display("unexpected %0t timeout", $time);
      finish_test();
    end
    if (strobe === 1'b1) nstrobe++;
    if (gate === 1'b1) gl++;
    else if (gl != 0) begin
      gate_len = gl;
      ngate++;
      gl = 0;
    end
    if (fine === 1'b0) fl++;
    else if (fl != 0) begin
      fine_len = fl;
      fl = 0;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %0t %s: got %0h expected %0h", $time, m, got, exp);
    end
  endtask
  // Classic single bus cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    rdat = bus_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n, 2, "bus ack");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(rdat, e, m);
  endtask
  // Poll status until it reads e
  task automatic wait_stat(input logic [31:0] e, input int gap);
    int n;
    n = 0;
    do begin
      repeat (gap) @(posedge clk_i);
      wb(1'b0, REG_STATUS, 32'h0, 4'hF);
      n++;
    end while (rdat !== e && n < 2000);
    chk(rdat, e, "status");
  endtask
  // Wait for one output pulse; t is its rise cycle
  task automatic pulse(output int t, input bit w);
    int n;
    n = 0;
    while (pps_out !== 1'b1 && n < 2 * PER) begin
      @(posedge clk_i);
      n++;
    end
    t = cyc_n;
    n = 0;
    while (pps_out !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (w) chk(n, PULSE_WIDTH_BUS * BUS_PERIOD_NS / CLK_PERIOD_NS, "width");
    repeat (200) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    int t, tp, e, d;
    logic [31:0] c;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(REG_CTRL, 32'h0, "ctrl reset");
    rd(REG_OFFSET, 32'h0, "offset reset");
    rd(REG_FINE_CODE, 32'h0, "code reset");
    rd(REG_STATUS, 32'h00000001, "status reset");
    wb(1'b1, REG_OFFSET, 32'hFFFFFFFF, 4'h1);
    rd(REG_OFFSET, 32'h000000FF, "byte lane");
    wb(1'b1, REG_OFFSET, 32'hFFFFFFFF, 4'hF);
    rd(REG_OFFSET, 32'h003FFFFF, "offset bits");
    wb(1'b1, REG_STATUS, 32'hFFFFFFFF, 4'hF);
    rd(REG_STATUS, 32'h00000001, "read only");
    wb(1'b1, 8'h09, 32'hFFFFFFFF, 4'hF);
    rd(REG_FINE_CODE, 32'h0, "unaligned write");
    rd(8'h20, 32'h0, "unmapped read");
    // Edge while idle: strobe only, no gate
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (400) @(posedge clk_i);
    chk(ngate, 0, "idle gate");
    chk(nstrobe, 1, "idle strobe");
    // Arm, tag one edge, then clear
    wb(1'b1, REG_CTRL, 32'h00000001, 4'hF);
    wait_stat(32'h00000002, 4);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    wait_stat(32'h00000320, 50);
    chk(ngate, 1, "one gate");
    chk(nstrobe, 2, "strobe");
    chk(fine_len, gate_len * STRETCH_FACTOR, "stretch");
    rd(REG_GATE_WIDTH, gate_len, "gate width");
    wb(1'b0, REG_COARSE_TAG, 32'h0, 4'hF);
    c = rdat;
    wb(1'b0, REG_FINE_TAG, 32'h0, 4'hF);
    d = int'((rdat - c) & 32'h0000FFFF);
    e = (fine_len + gate_len) * CLK_PERIOD_NS / BUS_PERIOD_NS;
    chk(32'(d >= e - 3 && d <= e + 3), 32'h00000001, "tag spacing");
    wb(1'b1, REG_CTRL, 32'h0, 4'hF);
    wait_stat(32'h00000001, 4);
    // Output placement: phase, coarse and fine steps
    wb(1'b1, REG_OFFSET, 32'h00000005, 4'hF);
    // Enable the timer outside its window so no pulse is cut short
    do wb(1'b0, REG_BUS_COUNT, 32'h0, 4'hF);
    while (rdat % PPS_P != 32);
    wb(1'b1, REG_CTRL, 32'h00000004, 4'hF);
    pulse(tp, 1'b0);
    pulse(tp, 1'b1);
    for (int s = 1; s < 4; s++) begin
      wb(1'b1, REG_CTRL, 32'(4 + 8 * s), 4'hF);
      pulse(t, 1'b1);
      chk(t - tp, PER + REF_CYCLES, "phase step");
      tp = t;
    end
    wb(1'b1, REG_OFFSET, 32'h00000006, 4'hF);
    pulse(t, 1'b1);
    chk(t - tp, PER + BUS_PERIOD_NS / CLK_PERIOD_NS, "coarse step");
    wb(1'b1, REG_FINE_CODE, 32'h000000FF, 4'hF);
    pulse(tp, 1'b1);
    chk(tp - t, PER + FINE_CODE_MAX * FINE_STEP_PS / CLK_PERIOD_PS, "fine");
    // Manual port bit drives the output with the timer off
    wb(1'b1, REG_CTRL, 32'h00000002, 4'hF);
    repeat (300) @(posedge clk_i);
    chk(32'(pps_out), 32'h00000001, "manual bit");
    finish_test();
  end
endmodule
